// ==== include/lane_xbar_defines.svh ====
// Register offsets, field positions and reset values of the upper lane crossbar.
// Assumes an 8-bit register port with a 12-bit address, as the serial config port delivers.
`ifndef LANE_XBAR_DEFINES_SVH
`define LANE_XBAR_DEFINES_SVH
`define XBAR_SEL_45_ADDR  12'h30a
`define XBAR_SEL_67_ADDR  12'h30b
`define FULL_STATUS_ADDR  12'h30c
`define EMPTY_STATUS_ADDR 12'h30d
`define SEL_EVEN_LSB      0
`define SEL_ODD_LSB       3
`define SEL_LANE4_RST     3'h4
`define SEL_LANE5_RST     3'h5
`define SEL_LANE6_RST     3'h6
`define SEL_LANE7_RST     3'h7
`define STATUS_RST        8'h00
`define LANES_RST         4'h0
`define RDATA_RST         8'h00
`endif

// ==== include/lane_xbar_pkg.sv ====
// Types shared by the upper lane crossbar.
// Assumes nothing beyond a SystemVerilog compiler.
package lane_xbar_pkg;
    typedef logic [2:0] lane_sel_t;
    typedef struct packed {
        lane_sel_t  sel4;
        lane_sel_t  sel5;
        lane_sel_t  sel6;
        lane_sel_t  sel7;
        logic [3:0] lanes;
        logic [7:0] full;
        logic [7:0] empty;
        logic [7:0] rdata;
    } xbar_state_s;
endpackage

// ==== rtl/serial_lane_crossbar_upper.sv ====
// Upper lane crossbar: routes physical serial lanes onto logical lanes 4 to 7,
// plus read-only receive FIFO full and empty status words.
// Assumes register writes/reads arrive as single-cycle strobes from the config port,
// and that lane data and FIFO flags are synchronous to ref_clk.
`timescale 1ns/10ps
`default_nettype none
`include "lane_xbar_defines.svh"

module serial_lane_crossbar_upper (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [11:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    input  wire logic [7:0]  physical_serial_input,
    input  wire logic [7:0]  lane_fifo_full,
    input  wire logic [7:0]  lane_fifo_empty,
    output logic      [3:0]  logical_lane_out
);
    lane_xbar_pkg::xbar_state_s st_r;
    lane_xbar_pkg::xbar_state_s st_nxt;

    // Select fields gathered per logical lane so one loop builds all four muxes
    logic [3:0][2:0] lane_sel;
    logic [3:0]      lane_mux;

    assign lane_sel = {st_r.sel7, st_r.sel6, st_r.sel5, st_r.sel4};

    // Binary index mux: code n picks physical lane n
    for (genvar k = 0; k < 4; k++) begin : g_lane_mux
        assign lane_mux[k] = physical_serial_input[lane_sel[k]];
    end

    always_comb begin
        st_nxt = st_r;
        // Full flags track the FIFOs; software cannot touch them
        st_nxt.full  = lane_fifo_full;
        st_nxt.empty = lane_fifo_empty;
        if (reg_wr) begin
            unique case (reg_addr)
                `XBAR_SEL_45_ADDR: begin
                    // Bits 7:6 are dropped on write
                    st_nxt.sel4 = reg_wdata[`SEL_EVEN_LSB +: 3];
                    st_nxt.sel5 = reg_wdata[`SEL_ODD_LSB +: 3];
                end
                `XBAR_SEL_67_ADDR: begin
                    st_nxt.sel6 = reg_wdata[`SEL_EVEN_LSB +: 3];
                    st_nxt.sel7 = reg_wdata[`SEL_ODD_LSB +: 3];
                end
                default: ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                `XBAR_SEL_45_ADDR:  st_nxt.rdata = {2'h0, st_r.sel5, st_r.sel4};
                `XBAR_SEL_67_ADDR:  st_nxt.rdata = {2'h0, st_r.sel7, st_r.sel6};
                `FULL_STATUS_ADDR:  st_nxt.rdata = st_r.full;
                `EMPTY_STATUS_ADDR: st_nxt.rdata = st_r.empty;
                default:            st_nxt.rdata = 8'h00;
            endcase
        end
        // Registered so lane outputs come from flip-flops, at one cycle of latency
        st_nxt.lanes = lane_mux;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_r.sel4  <= `SEL_LANE4_RST;
            st_r.sel5  <= `SEL_LANE5_RST;
            st_r.sel6  <= `SEL_LANE6_RST;
            st_r.sel7  <= `SEL_LANE7_RST;
            st_r.lanes <= `LANES_RST;
            st_r.full  <= `STATUS_RST;
            st_r.empty <= `STATUS_RST;
            st_r.rdata <= `RDATA_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata        = st_r.rdata;
    assign logical_lane_out = st_r.lanes;

    // Lane outputs lag the inputs by one cycle, selects included
    a_lane5_route: assert property (@(posedge ref_clk) disable iff (rst)
        !$past(rst)
        |-> logical_lane_out[1] == $past(physical_serial_input[st_r.sel5]))
        else $error("Lane 5 route mismatch");

    a_lane4_route: assert property (@(posedge ref_clk) disable iff (rst)
        !$past(rst)
        |-> logical_lane_out[0] == $past(physical_serial_input[st_r.sel4]))
        else $error("Lane 4 route mismatch");

    a_lane7_route: assert property (@(posedge ref_clk) disable iff (rst)
        !$past(rst)
        |-> logical_lane_out[3] == $past(physical_serial_input[st_r.sel7]))
        else $error("Lane 7 route mismatch");

    a_lane6_route: assert property (@(posedge ref_clk) disable iff (rst)
        !$past(rst)
        |-> logical_lane_out[2] == $past(physical_serial_input[st_r.sel6]))
        else $error("Lane 6 route mismatch");

    // Selects leave reset pointing at their own physical lanes
    a_lane4_rst: assert property (@(posedge ref_clk) disable iff (rst)
        $past(rst)
        |-> st_r.sel4 == `SEL_LANE4_RST)
        else $error("Lane 4 select reset wrong");

    a_lane5_rst: assert property (@(posedge ref_clk) disable iff (rst)
        $past(rst)
        |-> st_r.sel5 == `SEL_LANE5_RST)
        else $error("Lane 5 select reset wrong");

    a_lane6_rst: assert property (@(posedge ref_clk) disable iff (rst)
        $past(rst)
        |-> st_r.sel6 == `SEL_LANE6_RST)
        else $error("Lane 6 select reset wrong");

    a_lane7_rst: assert property (@(posedge ref_clk) disable iff (rst)
        $past(rst)
        |-> st_r.sel7 == `SEL_LANE7_RST)
        else $error("Lane 7 select reset wrong");

    a_full_rst: assert property (@(posedge ref_clk) disable iff (rst)
        $past(rst)
        |-> st_r.full == `STATUS_RST && reg_rdata == `RDATA_RST)
        else $error("Status reset wrong");

    // A write reaches the lane output two edges later; code n picks lane n
    a_sel_decode: assert property (@(posedge ref_clk) disable iff (rst)
        reg_wr && reg_addr == `XBAR_SEL_45_ADDR
        |-> ##2 logical_lane_out[0] ==
            |($past(physical_serial_input) & (8'h01 << $past(reg_wdata[2:0], 2))))
        else $error("Select decode wrong");

    a_sel5_decode: assert property (@(posedge ref_clk) disable iff (rst)
        reg_wr && reg_addr == `XBAR_SEL_45_ADDR
        |-> ##2 logical_lane_out[1] ==
            |($past(physical_serial_input) & (8'h01 << $past(reg_wdata[5:3], 2))))
        else $error("Lane 5 decode wrong");

    a_sel6_decode: assert property (@(posedge ref_clk) disable iff (rst)
        reg_wr && reg_addr == `XBAR_SEL_67_ADDR
        |-> ##2 logical_lane_out[2] ==
            |($past(physical_serial_input) & (8'h01 << $past(reg_wdata[2:0], 2))))
        else $error("Lane 6 decode wrong");

    a_sel7_decode: assert property (@(posedge ref_clk) disable iff (rst)
        reg_wr && reg_addr == `XBAR_SEL_67_ADDR
        |-> ##2 logical_lane_out[3] ==
            |($past(physical_serial_input) & (8'h01 << $past(reg_wdata[5:3], 2))))
        else $error("Lane 7 decode wrong");

    // Field placement inside the shared select registers
    a_resv_zero: assert property (@(posedge ref_clk) disable iff (rst)
        $past(reg_rd) && !$past(rst)
        && ($past(reg_addr) == `XBAR_SEL_45_ADDR || $past(reg_addr) == `XBAR_SEL_67_ADDR)
        |-> reg_rdata[7:6] == 2'h0)
        else $error("Reserved bits not zero");

    a_even_field: assert property (@(posedge ref_clk) disable iff (rst)
        reg_wr && reg_addr == `XBAR_SEL_45_ADDR
        |=> st_r.sel4 == $past(reg_wdata[2:0]))
        else $error("Lane 4 select not in 2:0");

    a_odd_field: assert property (@(posedge ref_clk) disable iff (rst)
        reg_wr && reg_addr == `XBAR_SEL_67_ADDR
        |=> st_r.sel7 == $past(reg_wdata[5:3]))
        else $error("Odd select not in 5:3");

    a_odd45_field: assert property (@(posedge ref_clk) disable iff (rst)
        reg_wr && reg_addr == `XBAR_SEL_45_ADDR
        |=> st_r.sel5 == $past(reg_wdata[5:3]))
        else $error("Lane 5 select not in 5:3");

    a_even67_field: assert property (@(posedge ref_clk) disable iff (rst)
        reg_wr && reg_addr == `XBAR_SEL_67_ADDR
        |=> st_r.sel6 == $past(reg_wdata[2:0]))
        else $error("Lane 6 select not in 2:0");

    // Status words: flags are registered once, then the read adds a cycle
    a_full_read: assert property (@(posedge ref_clk) disable iff (rst)
        reg_rd && reg_addr == `FULL_STATUS_ADDR && !$past(rst)
        |=> reg_rdata == $past(lane_fifo_full, 2))
        else $error("Full status read wrong");

    a_full_track: assert property (@(posedge ref_clk) disable iff (rst)
        !$past(rst)
        |-> st_r.full == $past(lane_fifo_full))
        else $error("Full flags not tracked");

    a_empty_read: assert property (@(posedge ref_clk) disable iff (rst)
        reg_rd && reg_addr == `EMPTY_STATUS_ADDR && !$past(rst)
        |=> reg_rdata == $past(lane_fifo_empty, 2))
        else $error("Empty status read wrong");

    a_empty_track: assert property (@(posedge ref_clk) disable iff (rst)
        !$past(rst)
        |-> st_r.empty == $past(lane_fifo_empty))
        else $error("Empty flags not tracked");

    // Writes outside the select registers leave routing alone
    a_status_wr: assert property (@(posedge ref_clk) disable iff (rst)
        reg_wr && (reg_addr == `FULL_STATUS_ADDR || reg_addr == `EMPTY_STATUS_ADDR)
        |=> $stable({st_r.sel4, st_r.sel5, st_r.sel6, st_r.sel7}))
        else $error("Status write changed routing");

    a_unmapped_wr: assert property (@(posedge ref_clk) disable iff (rst)
        reg_wr && reg_addr != `XBAR_SEL_45_ADDR && reg_addr != `XBAR_SEL_67_ADDR
        |=> $stable({st_r.sel4, st_r.sel5, st_r.sel6, st_r.sel7}))
        else $error("Stray write changed routing");
endmodule

`default_nettype wire

// ==== bench/lane_transmitter.sv ====
// Far-side model: a transmitter driving the eight physical serial lanes.
// Assumes a shared ref_clk; lanes change every cycle so a wrong route shows.
`timescale 1ns/10ps
`default_nettype none
module lane_transmitter (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    output var  logic [7:0] lanes
);
    // Odd step keeps lane 0 toggling and mixes the upper lanes
    always_ff @(posedge ref_clk) lanes <= rst ? 8'h00 : lanes + 8'h3b;
endmodule
`default_nettype wire

// ==== bench/serial_lane_crossbar_upper_tb.sv ====
// Bench of the upper lane crossbar: register reads, writes and lane routing.
// Assumes the strobe register port and one-cycle lane latency.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; \
    $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module serial_lane_crossbar_upper_tb;
    logic        ref_clk, rst, reg_wr, reg_rd;
    logic [11:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, lanes, full, empty, p;
    logic [3:0]  lane_out;
    int          err_count, comparisons;
    lane_transmitter tx (.ref_clk(ref_clk), .rst(rst), .lanes(lanes));
    serial_lane_crossbar_upper dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .physical_serial_input(lanes), .lane_fifo_full(full), .lane_fifo_empty(empty),
        .logical_lane_out(lane_out));
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 `CHK(reg_rdata, e)
    endtask
    // Selects packed {lane7, lane6, lane5, lane4}; output is last cycle's input
    task automatic chk(input logic [11:0] s);
        repeat (3) begin
            @(posedge ref_clk);
            p = lanes;
            #1 `CHK(lane_out, {p[s[11:9]], p[s[8:6]], p[s[5:3]], p[s[2:0]]})
        end
    endtask
    task stop_test;
        $display("err_count %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #300000 err_count++;
        stop_test();
    end
    initial begin
        {rst, reg_wr, reg_rd, reg_addr, reg_wdata, full, empty} = {3'b100, 36'h0};
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        rd(12'h30a, 8'h2c);
        rd(12'h30b, 8'h3e);
        rd(12'h30c, 8'h00);
        chk(12'hfac);
        for (int i = 0; i < 8; i++) begin
            wr(12'h30a, {2'b11, 3'(7 - i), 3'(i)});
            wr(12'h30b, {2'b11, 3'(i), 3'(7 - i)});
            rd(12'h30a, {2'b00, 3'(7 - i), 3'(i)});
            chk({3'(i), 3'(7 - i), 3'(7 - i), 3'(i)});
        end
        @(posedge ref_clk);
        full <= 8'ha5;
        empty <= 8'h3c;
        wr(12'h30c, 8'hff);
        wr(12'h30d, 8'h00);
        rd(12'h30c, 8'ha5);
        rd(12'h30d, 8'h3c);
        rd(12'h30e, 8'h00);
        rd(12'h30a, 8'h07);
        rd(12'h30b, 8'h38);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rd(12'h30a, 8'h2c);
        rd(12'h30b, 8'h3e);
        chk(12'hfac);
        stop_test();
    end
endmodule
`default_nettype wire
